// >>> hdl/reset_source_sequencer.sv
// reset source sequencer: reset kinds, pins, config latch and registers
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module reset_source_sequencer (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire rss_pkg::rss_pins_t pinsIn,
  input  wire logic              pllBypass,
  input  wire logic              swResetExec,
  input  wire logic              endOfInitExec,
  input  wire logic              wdtOverflow,
  input  wire logic              busCycleActive,
  input  wire logic              busUsesReady,
  input  wire logic              waitStatesDone,
  input  wire rss_pkg::rss_req_t regReq,
  output logic [15:0]            regRdata,
  output logic                   resetOutN,
  output logic                   rstInPullOut,
  output logic                   rstInPullOe,
  output logic                   capDischargeEn,
  output logic                   capPullupEn,
  output logic                   cancelHold,
  output logic                   busAbort,
  output logic                   cpuRun,
  output logic [23:0]            fetchAddr
);

  // sampling mask per reset kind
  function automatic logic [15:0] sampleMask(rss_pkg::rss_kind_t k);
    case (k)
      rss_pkg::KIND_SW,
      rss_pkg::KIND_WDT:   sampleMask = rss_pkg::MASK_SW;
      rss_pkg::KIND_SHORT: sampleMask = rss_pkg::MASK_SHORT;
      default:             sampleMask = rss_pkg::MASK_ALL;
    endcase
  endfunction

  function automatic logic softKind(rss_pkg::rss_kind_t k);
    softKind = (k == rss_pkg::KIND_SW) || (k == rss_pkg::KIND_WDT);
  endfunction

  rss_pkg::rss_pins_t  meta_q, pins_q;
  rss_pkg::rss_state_t state_q, state_d;
  rss_pkg::rss_kind_t  kind_q, kind_d;
  logic [rss_pkg::CNT_W-1:0] cnt_q, lowCnt_q;
  logic [15:0] latched_q, system_config_reg_q, buscon_q;
  logic        initDone_q, asyncSeen_q, pull_q, resetOutN_q;
  logic        capPull_q, capDis_q, cancel_q, abort_q, run_q;
  logic        pinLow, hwDetect, asyncCond, seqStart, latchNow;
  logic        pullD1_q, pullD2_q, ownLow;
  logic [rss_pkg::CNT_W-1:0] latchCyc;
  logic [15:0] mask;

  // pins cross from outside: two flops before any use
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '1;
      pins_q <= '1;
    end else begin
      meta_q <= pinsIn;
      pins_q <= meta_q;
    end
  end

  assign pinLow = !pins_q.rstInN;
  // own pull makes the pin low, so it is not a fresh hardware request
  assign hwDetect = (lowCnt_q >= rss_pkg::CNT_W'(rss_pkg::DETECT_CYC - 1))
                    && pinLow && !pull_q;
  assign asyncCond = !pins_q.capAbove && (pinLow || pull_q);
  // own pull still seen low through the pin flops for two cycles
  assign ownLow = pull_q || pullD1_q || pullD2_q;
  assign latchCyc = pllBypass ? rss_pkg::CNT_W'(rss_pkg::LATCH_BYP_CYC)
                              : rss_pkg::CNT_W'(rss_pkg::LATCH_CYC);
  assign mask = sampleMask(kind_q);

  // low-time counter for hardware detection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lowCnt_q <= '0;
    end else if (!pinLow || pull_q) begin
      lowCnt_q <= '0;
    end else if (!(&lowCnt_q)) begin
      lowCnt_q <= lowCnt_q + 1'b1;
    end
  end

  always_comb begin
    state_d  = state_q;
    kind_d   = kind_q;
    seqStart = 1'b0;
    latchNow = 1'b0;
    case (state_q)
      rss_pkg::ST_RUN: begin
        if (hwDetect && !pins_q.capAbove) begin
          state_d  = rss_pkg::ST_ASYNC;
          kind_d   = rss_pkg::KIND_LONG;
          seqStart = 1'b1;
        end else if (hwDetect) begin
          state_d  = rss_pkg::ST_SYNC;
          kind_d   = rss_pkg::KIND_SHORT;
          seqStart = 1'b1;
        end else if (swResetExec) begin
          state_d  = rss_pkg::ST_SYNC;
          kind_d   = rss_pkg::KIND_SW;
          seqStart = 1'b1;
        end else if (wdtOverflow) begin
          state_d  = rss_pkg::ST_WDT_BUS;
          kind_d   = rss_pkg::KIND_WDT;
          seqStart = 1'b1;
        end
      end
      rss_pkg::ST_WDT_BUS: begin
        // finish the cycle unless READY stays high after wait states
        if (!busCycleActive) begin
          state_d = rss_pkg::ST_SEQ;
        end else if (busUsesReady && waitStatesDone && pins_q.readyN) begin
          state_d = rss_pkg::ST_SEQ;
        end
      end
      rss_pkg::ST_SYNC: begin
        if (asyncCond) begin
          state_d = rss_pkg::ST_ASYNC;
          kind_d  = rss_pkg::KIND_LONG;
        end else if (cnt_q == '0) begin
          state_d = rss_pkg::ST_SEQ;
        end
      end
      rss_pkg::ST_SEQ: begin
        if (asyncCond) begin
          state_d = rss_pkg::ST_ASYNC;
          kind_d  = rss_pkg::KIND_LONG;
        end else if (cnt_q == '0) begin
          state_d = rss_pkg::ST_EXTEND;
        end
      end
      rss_pkg::ST_EXTEND: begin
        if (pinLow && !ownLow && !pins_q.capAbove) begin
          state_d = rss_pkg::ST_ASYNC;
          kind_d  = rss_pkg::KIND_LONG;
        end else if (pinLow && !ownLow) begin
          kind_d  = rss_pkg::KIND_LONG;
        end else begin
          state_d = rss_pkg::ST_LATCH;
        end
      end
      rss_pkg::ST_ASYNC: begin
        if (!pinLow) begin
          state_d = rss_pkg::ST_LATCH;
        end
      end
      rss_pkg::ST_LATCH: begin
        if (cnt_q == '0) begin
          state_d  = rss_pkg::ST_RUN;
          latchNow = 1'b1;
        end
      end
      default: begin
        state_d = rss_pkg::ST_ASYNC;
      end
    endcase
  end

  // power-on enters the asynchronous hold, capacitor assumed discharged
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= rss_pkg::ST_ASYNC;
      kind_q  <= rss_pkg::KIND_POR;
    end else begin
      state_q <= state_d;
      kind_q  <= kind_d;
    end
  end

  // phase timer reloaded on each state entry
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (state_d != state_q) begin
      case (state_d)
        rss_pkg::ST_SYNC:
          cnt_q <= rss_pkg::CNT_W'(rss_pkg::SYNC_CYC - 1);
        rss_pkg::ST_SEQ:
          cnt_q <= rss_pkg::CNT_W'(rss_pkg::SEQ_CYC - 1);
        rss_pkg::ST_LATCH:
          cnt_q <= rss_pkg::CNT_W'(latchCyc - 1'b1);
        default:
          cnt_q <= '0;
      endcase
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // reset output and init phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resetOutN_q <= 1'b0;
      initDone_q  <= 1'b0;
    end else if (seqStart) begin
      resetOutN_q <= 1'b0;
      initDone_q  <= 1'b0;
    end else if (endOfInitExec && run_q && !initDone_q) begin
      resetOutN_q <= 1'b1;
      initDone_q  <= 1'b1;
    end
  end

  // open-drain pull only inside the internal sequence
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pull_q   <= 1'b0;
      pullD1_q <= 1'b0;
      pullD2_q <= 1'b0;
    end else begin
      pullD1_q <= pull_q;
      pullD2_q <= pullD1_q;
      pull_q <= (state_d == rss_pkg::ST_SEQ)
                && system_config_reg_q[rss_pkg::SYS_BIDIR] && !asyncCond;
    end
  end

  // capacitor pin helpers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      capDis_q  <= 1'b0;
      capPull_q <= 1'b0;
    end else begin
      capDis_q <= pinLow || pull_q;
      if (seqStart) begin
        capPull_q <= 1'b0;
      end else if (latchNow) begin
        capPull_q <= system_config_reg_q[rss_pkg::SYS_POWERDOWN_CONFIG];
      end
    end
  end

  // hold cancel during sync window; bus abort at sync entry or on leaving the watchdog bus wait while a bus cycle is still active
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cancel_q <= 1'b0;
      abort_q  <= 1'b0;
      run_q    <= 1'b0;
    end else begin
      cancel_q <= (state_d == rss_pkg::ST_SYNC);
      abort_q  <= (state_d == rss_pkg::ST_SYNC && state_q == rss_pkg::ST_RUN)
                  || (state_q == rss_pkg::ST_WDT_BUS
                      && state_d == rss_pkg::ST_SEQ && busCycleActive);
      run_q    <= (state_d == rss_pkg::ST_RUN);
    end
  end

  // configuration latch
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latched_q <= '0;
    end else if (latchNow) begin
      latched_q <= (pins_q.port0 & mask)
                   | (latched_q & ~mask
                      & (softKind(kind_q) ? ~rss_pkg::MASK_CLR_SW
                                          : rss_pkg::MASK_ALL));
    end
  end

  // system config: software bits plus derived fields
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      system_config_reg_q <= '0;
    end else if (latchNow) begin
      // cleared at the end so the pull can act during the sequence
      system_config_reg_q[rss_pkg::SYS_BIDIR]  <= 1'b0;
      system_config_reg_q[rss_pkg::SYS_WRITE_CONFIG_FIELD]  <=
        !((pins_q.port0 & mask) != rss_pkg::ZERO16 && pins_q.port0[rss_pkg::P0_WRC]
          ? 1'b1 : latched_q[rss_pkg::P0_WRC] & !mask[rss_pkg::P0_WRC]);
      system_config_reg_q[rss_pkg::SYS_BYTE_HIGH_DISABLE] <= !(mask[rss_pkg::P0_BUSW]
        ? pins_q.port0[rss_pkg::P0_BUSW]
        : latched_q[rss_pkg::P0_BUSW]);
    end else if (regReq.wr && regReq.addr == rss_pkg::REG_SYSTEM_CONFIG_REG) begin
      system_config_reg_q[rss_pkg::SYS_POWERDOWN_CONFIG] <= regReq.wdata[rss_pkg::SYS_POWERDOWN_CONFIG];
      if (!initDone_q) begin
        system_config_reg_q[rss_pkg::SYS_BIDIR] <= regReq.wdata[rss_pkg::SYS_BIDIR];
      end
    end else if (asyncCond && state_q != rss_pkg::ST_RUN) begin
      system_config_reg_q[rss_pkg::SYS_BIDIR] <= 1'b0;
    end
  end

  // bus config 0 loaded once per reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      buscon_q <= '0;
    end else if (latchNow) begin
      buscon_q <= '0;
      buscon_q[rss_pkg::BUS_TYPE_LO +: 2] <=
        mask[rss_pkg::BUS_TYPE_LO] ? pins_q.port0[rss_pkg::BUS_TYPE_LO +: 2]
                                   : latched_q[rss_pkg::BUS_TYPE_LO +: 2];
      buscon_q[rss_pkg::BUS_ACT] <= pins_q.extAccess;
      buscon_q[rss_pkg::BUS_ALE] <= pins_q.extAccess;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      asyncSeen_q <= 1'b1;
    end else if (seqStart) begin
      asyncSeen_q <= 1'b0;
    end else if (state_q == rss_pkg::ST_ASYNC) begin
      asyncSeen_q <= 1'b1;
    end
  end

  // read data one cycle after the strobe; unmapped cannot occur
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regRdata <= '0;
    end else if (regReq.rd) begin
      case (regReq.addr)
        rss_pkg::REG_SYSTEM_CONFIG_REG:  regRdata <= system_config_reg_q;
        rss_pkg::REG_BUS_CONFIG0_REG: regRdata <= buscon_q;
        rss_pkg::REG_LATCHED_CONFIG_STRAP:    regRdata <= {8'h00, latched_q[15:8]};
        rss_pkg::REG_STATUS:
          regRdata <= {11'h000, asyncSeen_q, initDone_q, kind_q};
        default:              regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  assign resetOutN      = resetOutN_q;
  assign rstInPullOut   = 1'b0;
  assign rstInPullOe    = pull_q;
  assign capDischargeEn = capDis_q;
  assign capPullupEn    = capPull_q;
  assign cancelHold     = cancel_q;
  assign busAbort       = abort_q;
  assign cpuRun         = run_q;
  assign fetchAddr      = rss_pkg::RESET_VECTOR;

endmodule
`default_nettype wire

// >>> hdl/rss_pkg.sv
// constants, types and layouts for the reset source sequencer
// Overview of operation
// - software reset instruction starts a 1024 half-clock internal sequence, like short reset.
// - after software reset, latch config bits 12..6 and clear latched bits 5..2.
// - watchdog overflow, when not disabled or serviced, triggers the reset sequence.
// - watchdog reset lets a running bus cycle finish without READY or READY low.
// - watchdog reset aborts the bus cycle if READY high, then runs 1024 sequence.
// - watchdog reset acts like software reset; latch bits 12..6, clear bits 5..2.
// - reset output driven low at the start of every reset sequence.
// - reset output stays low until the end-of-init instruction completes.
// - bidirectional enable is bit 3 of system config; every sequence clears it.
// - bidirectional enable may be set only before end-of-init completes.
// - capacitor below threshold with reset pin low: stop pulling, run asynchronous.
// - with bidirectional enabled, pull reset pin low for the whole internal sequence.
// - pull on reset pin released before the first instruction fetch.
// - capacitor discharge pull-down on whenever reset pin is low.
// - powerdown config set: capacitor pull-up enabled at end of reset sequence.
// - hardware reset asynchronous below capacitor threshold, synchronous above it.
// - power-on sees a discharged capacitor and performs an asynchronous reset.
// - software and watchdog resets sample only config bits 12 down to 6.
// - short reset samples bits 12..0; long and power-on resets sample all 16.
// - config high byte copied to low byte of latched port register, same order.
// - bus type from config bits 7..6; bus active and latch control follow access pin.
// - byte-high disable and write config derived indirectly from latched config.
// - at most 12 half-clocks cancel holds and abort external bus cycle.
// - configuration latched 8 half-clocks after reset end, 6 when PLL bypassed.
// - execution starts at address 00'0000h in code segment zero.
package rss_pkg;

  localparam int CLK_PERIOD_PS  = 5000;
  localparam int HALF_CLK_PS    = 5000;  // one half CPU period per clock
  localparam int SEQ_TCL        = 1024;
  localparam int DETECT_TCL     = 4;
  localparam int SYNC_TCL       = 12;
  localparam int LATCH_TCL      = 8;
  localparam int LATCH_BYP_TCL  = 6;
  localparam int SEQ_CYC    = SEQ_TCL * HALF_CLK_PS / CLK_PERIOD_PS;
  localparam int DETECT_CYC =
    (DETECT_TCL * HALF_CLK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_CYC   = SYNC_TCL * HALF_CLK_PS / CLK_PERIOD_PS;
  localparam int LATCH_CYC  =
    (LATCH_TCL * HALF_CLK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LATCH_BYP_CYC =
    (LATCH_BYP_TCL * HALF_CLK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 11;

  localparam logic [1:0] REG_SYSTEM_CONFIG_REG  = 2'h0;
  localparam logic [1:0] REG_BUS_CONFIG0_REG = 2'h1;
  localparam logic [1:0] REG_LATCHED_CONFIG_STRAP    = 2'h2;
  localparam logic [1:0] REG_STATUS  = 2'h3;

  localparam int SYS_BIDIR  = 3;
  localparam int SYS_POWERDOWN_CONFIG = 5;
  localparam int SYS_WRITE_CONFIG_FIELD  = 7;
  localparam int SYS_BYTE_HIGH_DISABLE = 9;
  localparam int BUS_TYPE_LO = 6;
  localparam int BUS_ALE     = 9;
  localparam int BUS_ACT     = 10;
  localparam int P0_WRC      = 8;
  localparam int P0_BUSW     = 7;

  localparam logic [15:0] SYS_WR_MASK  = 16'h0028;
  localparam logic [15:0] MASK_SW      = 16'h1FC0;
  localparam logic [15:0] MASK_SHORT   = 16'h1FFF;
  localparam logic [15:0] MASK_ALL     = 16'hFFFF;
  localparam logic [15:0] MASK_CLR_SW  = 16'h003C;
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [23:0] RESET_VECTOR = 24'h000000;

  typedef enum logic [2:0] {
    KIND_POR, KIND_LONG, KIND_SHORT, KIND_SW, KIND_WDT
  } rss_kind_t;

  typedef enum logic [2:0] {
    ST_RUN, ST_WDT_BUS, ST_SYNC, ST_SEQ, ST_EXTEND, ST_ASYNC, ST_LATCH
  } rss_state_t;

  typedef struct packed {
    logic        rstInN;
    logic        capAbove;
    logic        readyN;
    logic        extAccess;
    logic [15:0] port0;
  } rss_pins_t;

  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } rss_req_t;

endpackage

// >>> test/rss_checker.sv
// port assertions for the reset source sequencer
`timescale 1ns/1ps
`default_nettype none
module rss_checker (
  input wire logic               clock,
  input wire logic               rst,
  input wire rss_pkg::rss_pins_t pinsIn,
  input wire logic               swResetExec,
  input wire logic               endOfInitExec,
  input wire logic               wdtOverflow,
  input wire logic               busUsesReady,
  input wire logic               waitStatesDone,
  input wire logic               resetOutN,
  input wire logic               rstInPullOut,
  input wire logic               rstInPullOe,
  input wire logic               capDischargeEn,
  input wire logic               cancelHold,
  input wire logic               busAbort,
  input wire logic               cpuRun,
  input wire logic [23:0]        fetchAddr
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence swTake;
    swResetExec && cpuRun;
  endsequence
  // abort pulse opens the cancel window, which then holds
  sequence syncWin;
    busAbort && cancelHold ##1 (!busAbort && cancelHold) [*8];
  endsequence

  start_low_a: assert property (
    swTake |=> !resetOutN && !cpuRun) else $error("no reset start");
  sync_window_a: assert property (
    swTake |=> syncWin) else $error("cancel window wrong");
  wdt_start_a: assert property (
    wdtOverflow && cpuRun |=> !resetOutN && !cancelHold)
    else $error("watchdog start wrong");
  abort_cause_a: assert property (
    busAbort && !cancelHold |-> $past(busUsesReady && waitStatesDone))
    else $error("abort without ready check");
  out_hold_a: assert property (
    $rose(resetOutN) |-> $past(endOfInitExec))
    else $error("reset out released early");
  eoi_release_a: assert property (
    endOfInitExec && cpuRun && !resetOutN |=> resetOutN)
    else $error("reset out not released");
  pull_window_a: assert property (
    rstInPullOe |-> !cpuRun && !rstInPullOut)
    else $error("pull during run");
  discharge_on_a: assert property (
    !pinsIn.rstInN [*5] |-> capDischargeEn) else $error("discharge off");
  discharge_off_a: assert property (
    pinsIn.rstInN [*5] |-> !capDischargeEn) else $error("discharge on");
  vector_zero_a: assert property (
    $rose(cpuRun) |-> fetchAddr == 24'h000000)
    else $error("start address wrong");
endmodule
`default_nettype wire

// >>> test/rss_ext_model.sv
// reset pin with pull-up and slow capacitor on the cap pin
`timescale 1ns/1ps
`default_nettype none
module rss_ext_model #(
  parameter int TH  = 1000,
  parameter int TOP = 4000
) (
  input wire logic  clock,
  input wire logic  extLow,
  input wire logic  pullOe,
  input wire logic  pullOut,
  input wire logic  capDis,
  input wire logic  capPull,
  output logic      pinN,
  output logic      capHi
);
  int lvl = 0;
  // discharged at power-on; slow enough that a short pull keeps it up
  always_ff @(posedge clock) begin
    if (capDis)
      lvl <= (lvl > 0) ? lvl - 1 : 0;
    else if (lvl < TOP)
      lvl <= lvl + (capPull ? 2 : 1);
  end
  assign pinN  = !(extLow || (pullOe && !pullOut));
  assign capHi = (lvl >= TH);
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the reset source sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0, rst = 1'b1, pllBypass = 1'b0, extAcc = 1'b1;
  logic swResetExec = 1'b0, endOfInitExec = 1'b0, wdtOverflow = 1'b0;
  logic busCycleActive = 1'b0, busUsesReady = 1'b0, waitStatesDone = 1'b0;
  logic readyN = 1'b0, extLow = 1'b0;
  logic [15:0] port0 = 16'hA5C3, lat = 16'h0000, regRdata;
  logic [23:0] fetchAddr;
  logic resetOutN, rstInPullOut, rstInPullOe, capDischargeEn, capPullupEn;
  logic cancelHold, busAbort, cpuRun, pinN, capHi;
  rss_pkg::rss_req_t  regReq = '0;
  rss_pkg::rss_pins_t pins;
  int compares = 0, miscompares = 0, cyc = 0;

  always #2.5 clock = ~clock;
  assign pins = '{rstInN: pinN, capAbove: capHi, readyN: readyN,
                  extAccess: extAcc, port0: port0};

  rss_ext_model ext (.clock(clock), .extLow(extLow), .pullOe(rstInPullOe),
    .pullOut(rstInPullOut), .capDis(capDischargeEn), .capPull(capPullupEn),
    .pinN(pinN), .capHi(capHi));
  reset_source_sequencer dut (.clock(clock), .rst(rst), .pinsIn(pins),
    .pllBypass(pllBypass), .swResetExec(swResetExec),
    .endOfInitExec(endOfInitExec), .wdtOverflow(wdtOverflow),
    .busCycleActive(busCycleActive), .busUsesReady(busUsesReady),
    .waitStatesDone(waitStatesDone), .regReq(regReq), .regRdata(regRdata),
    .resetOutN(resetOutN), .rstInPullOut(rstInPullOut),
    .rstInPullOe(rstInPullOe), .capDischargeEn(capDischargeEn),
    .capPullupEn(capPullupEn), .cancelHold(cancelHold),
    .busAbort(busAbort), .cpuRun(cpuRun), .fetchAddr(fetchAddr));

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, s);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    regReq.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clock);
    regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    regReq.rd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic waitRun(output int n);
    n = 0;
    while (cpuRun !== 1'b1 && n < 5000) begin
      @(posedge clock);
      #1 n++;
    end
    chk("run", 16'h0001, {15'h0, cpuRun});
  endtask

  task automatic chkLat(input logic [15:0] msk, clr, km, ke);
    logic [15:0] d;
    lat = (lat & ~msk & ~clr) | (port0 & msk);
    rd(2'h2, d);
    chk("latched", {8'h00, lat[15:8]}, d);
    rd(2'h3, d);
    chk("status", ke, d & km);
  endtask

  task automatic sc_por();
    logic [15:0] d;
    int n;
    waitRun(n);
    chk("reset_out_n", 16'h0000, {15'h0, resetOutN});
    chkLat(16'hFFFF, 16'h0000, 16'h0007, 16'h0000);
    rd(2'h1, d);
    chk("bus", {5'h0, extAcc, extAcc, 1'b0, port0[7:6], 6'h0},
        d & 16'h06C0);
    rd(2'h0, d);
    chk("sys", {6'h0, ~port0[7], 1'b0, ~port0[8], 7'h0},
        d & 16'h0280);
  endtask

  task automatic sc_init();
    logic [15:0] d, b;
    wr(2'h0, 16'h0028);
    rd(2'h0, d);
    chk("bidir on", 16'h0028, d & 16'h0028);
    @(posedge clock);
    endOfInitExec <= 1'b1;
    @(posedge clock);
    endOfInitExec <= 1'b0;
    #1 chk("reset_out_n", 16'h0001, {15'h0, resetOutN});
    wr(2'h0, 16'h0020);
    rd(2'h0, d);
    chk("bidir kept", 16'h0028, d & 16'h0028);
    rd(2'h1, b);
    wr(2'h1, ~b);
    rd(2'h1, d);
    chk("bus ro", b, d);
  endtask

  task automatic sc_sw();
    logic [15:0] d;
    int n;
    // capacitor must stay above threshold through the own pull
    wait (ext.lvl >= 2500);
    port0 <= 16'h5A3C;
    @(posedge clock);
    swResetExec <= 1'b1;
    @(posedge clock);
    swResetExec <= 1'b0;
    #1 chk("reset_out_n", 16'h0000, {15'h0, resetOutN});
    repeat (20) @(posedge clock);
    #1 chk("pull", 16'h0001, {15'h0, rstInPullOe});
    waitRun(n);
    n += 21;
    chk("seq len", 16'h0001, {15'h0, n >= 1036 && n <= 1060});
    chkLat(16'h1FC0, 16'h003C, 16'h0007, 16'h0003);
    rd(2'h0, d);
    chk("bidir clr", 16'h0000, d & 16'h0008);
    chk("pullup", 16'h0001, {15'h0, capPullupEn});
  endtask

  task automatic sc_wdt();
    int n;
    port0 <= 16'h3C5A;
    busCycleActive <= 1'b1;
    waitStatesDone <= 1'b1;
    readyN <= 1'b1;
    @(posedge clock);
    wdtOverflow <= 1'b1;
    @(posedge clock);
    wdtOverflow <= 1'b0;
    n = 0;
    repeat (10) begin
      @(posedge clock);
      #1 n += (busAbort === 1'b1);
    end
    chk("no abort", 16'h0000, n[15:0]);
    busUsesReady <= 1'b1;
    n = 0;
    while (busAbort !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1 n++;
    end
    chk("abort", 16'h0001, {15'h0, busAbort});
    chk("reset_out_n", 16'h0000, {15'h0, resetOutN});
    busCycleActive <= 1'b0;
    busUsesReady <= 1'b0;
    waitRun(n);
    chkLat(16'h1FC0, 16'h003C, 16'h0007, 16'h0004);
  endtask

  task automatic hwPulse(input logic [15:0] p, input int len);
    port0 <= p;
    @(posedge clock);
    extLow <= 1'b1;
    repeat (len) @(posedge clock);
    extLow <= 1'b0;
  endtask

  task automatic sc_hw();
    int n;
    hwPulse(16'hC3A5, 20);
    waitRun(n);
    chkLat(16'h1FFF, 16'h0000, 16'h0007, 16'h0002);
    // long enough for the capacitor to fall below threshold
    hwPulse(16'h6E91, 3500);
    waitRun(n);
    chkLat(16'hFFFF, 16'h0000, 16'h0010, 16'h0010);
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    sc_por();
    sc_init();
    sc_sw();
    sc_wdt();
    sc_hw();
    wrap_up();
  end
endmodule

bind reset_source_sequencer rss_checker u_chk (.clock(clock), .rst(rst),
  .pinsIn(pinsIn), .swResetExec(swResetExec), .endOfInitExec(endOfInitExec),
  .wdtOverflow(wdtOverflow), .busUsesReady(busUsesReady),
  .waitStatesDone(waitStatesDone), .resetOutN(resetOutN),
  .rstInPullOut(rstInPullOut), .rstInPullOe(rstInPullOe),
  .capDischargeEn(capDischargeEn), .cancelHold(cancelHold),
  .busAbort(busAbort), .cpuRun(cpuRun), .fetchAddr(fetchAddr));
`default_nettype wire
